// *** logic/btimr_core.sv ***
// dual-ported host interrupt mask register: slave side and host side
`timescale 1ns/1ps
`default_nettype none
`include "btimr_cfg.svh"
module btimr_core
  import btimr_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // slave processor access
  input  wire logic             slvRd,
  input  wire logic             slvWr,
  input  wire btimr_byte_type   slvWdata,
  output btimr_byte_type        slvRdata_q,
  output logic                  slvRdValid_q,
  // host access, already decoded from the host interface
  input  wire logic             hstRd,
  input  wire logic             hstWr,
  input  wire btimr_byte_type   hstWdata,
  output btimr_byte_type        hstRdata_q,
  output logic                  hstRdValid_q,
  // control from a neighbouring register
  input  wire logic             resetReadbackEnable,
  // state toward the rest of the device
  output logic                  slaveResetReq_q,
  output logic                  userFlag3_q,
  output logic                  userFlag2_q,
  output logic                  userFlag1_q,
  output logic                  slaveToHostIrq_q,
  output logic                  slaveToHostIrqEnable_q,
  output logic                  hostIrqPending_q,
  output logic                  slaveResetRise_q
);

  ////////////////////////////////////////////////////////////////////////////
  // register image

  logic       rstReq;
  logic       user2;
  logic       user1;
  logic       irq;
  logic       irqEn;
  logic [1:0] rsvd_q;
  logic       user3_q;
  btimr_byte_type regImage;

  // reset image split per field, so one constant sets every bit
  localparam btimr_byte_type RESET_IMAGE = `BTIMR_RESET_VALUE;
  localparam logic       RST_REQ_INIT = RESET_IMAGE[`BTIMR_BIT_RST_REQ];
  localparam logic [1:0] RSVD_INIT    = RESET_IMAGE[`BTIMR_BIT_RSVD_HI:`BTIMR_BIT_RSVD_LO];
  localparam logic       USER3_INIT   = RESET_IMAGE[`BTIMR_BIT_USER3];
  localparam logic       USER2_INIT   = RESET_IMAGE[`BTIMR_BIT_USER2];
  localparam logic       USER1_INIT   = RESET_IMAGE[`BTIMR_BIT_USER1];
  localparam logic       IRQ_INIT     = RESET_IMAGE[`BTIMR_BIT_IRQ];
  localparam logic       IRQ_EN_INIT  = RESET_IMAGE[`BTIMR_BIT_IRQ_EN];

  assign regImage = {
    rstReq,
    rsvd_q,
    user3_q,
    user2,
    user1,
    irq,
    irqEn
  };

  ////////////////////////////////////////////////////////////////////////////
  // shared next-value rule

  // same priority as the flag cells, so the mirrors never drift from them
  function automatic logic flagNext(
    input logic setEv,
    input logic clrEv,
    input logic cur
  );
    if (setEv)
      return 1'b1;
    else if (clrEv)
      return 1'b0;
    else
      return cur;
  endfunction : flagNext

  ////////////////////////////////////////////////////////////////////////////
  // slave read snapshot

  btimr_byte_type seenOne;
  btimr_byte_type seenZero;

  btimr_read_arm #(
    .WIDTH (`BTIMR_DATA_W)
  ) u_arm (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .rdEn     (slvRd),
    .rdVal    (regImage),
    .wrEn     (slvWr),
    .seenOne  (seenOne),
    .seenZero (seenZero)
  );

  // qualifiers that a slave write to each flag must meet
  wire logic rstSeenOne  = seenOne[`BTIMR_BIT_RST_REQ];
  wire logic u2SeenOne   = seenOne[`BTIMR_BIT_USER2];
  wire logic u2SeenZero  = seenZero[`BTIMR_BIT_USER2];
  wire logic u1SeenOne   = seenOne[`BTIMR_BIT_USER1];
  wire logic u1SeenZero  = seenZero[`BTIMR_BIT_USER1];
  wire logic irqSeenZero = seenZero[`BTIMR_BIT_IRQ];

  ////////////////////////////////////////////////////////////////////////////
  // write decode per bit and side

  // host side: only a 1 sets the reset request, a 0 is ignored
  wire logic hstRstSet  = hstWr & hstWdata[`BTIMR_BIT_RST_REQ];

  // slave side: clear only after the request was seen as 1
  wire logic slvRstClr  = slvWr & ~slvWdata[`BTIMR_BIT_RST_REQ]
                        & rstSeenOne;

  // host sets a user flag by writing 0; a 1 leaves it alone
  wire logic hstU2Set   = hstWr & ~hstWdata[`BTIMR_BIT_USER2];
  wire logic hstU1Set   = hstWr & ~hstWdata[`BTIMR_BIT_USER1];

  // slave toggles a user flag only against what it read before
  wire logic slvU2Clr   = slvWr & ~slvWdata[`BTIMR_BIT_USER2]
                        & u2SeenOne;
  wire logic slvU1Clr   = slvWr & ~slvWdata[`BTIMR_BIT_USER1]
                        & u1SeenOne;
  wire logic slvU2Set   = slvWr & slvWdata[`BTIMR_BIT_USER2]
                        & u2SeenZero;
  wire logic slvU1Set   = slvWr & slvWdata[`BTIMR_BIT_USER1]
                        & u1SeenZero;

  wire logic u2Set      = hstU2Set | slvU2Set;
  wire logic u1Set      = hstU1Set | slvU1Set;

  // slave raises the host interrupt only after it read the bit as 0
  wire logic slvIrqSet  = slvWr & slvWdata[`BTIMR_BIT_IRQ]
                        & irqSeenZero;

  // host acknowledges with a 1; a 0 write has no effect
  wire logic hstIrqClr  = hstWr & hstWdata[`BTIMR_BIT_IRQ];

  // enable belongs to the host alone; slave writes never reach it
  wire logic irqEnWr    = hstWr;
  wire logic irqEnSet   = irqEnWr & hstWdata[`BTIMR_BIT_IRQ_EN];
  wire logic irqEnClr   = irqEnWr & ~hstWdata[`BTIMR_BIT_IRQ_EN];

  ////////////////////////////////////////////////////////////////////////////
  // flag cells

  btimr_flag #(
    .RESET_VAL (RST_REQ_INIT)
  ) u_rst_req (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setEv   (hstRstSet),
    .clrEv   (slvRstClr),
    .flag_q  (rstReq)
  );

  btimr_flag #(
    .RESET_VAL (USER2_INIT)
  ) u_user2 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setEv   (u2Set),
    .clrEv   (slvU2Clr),
    .flag_q  (user2)
  );

  btimr_flag #(
    .RESET_VAL (USER1_INIT)
  ) u_user1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setEv   (u1Set),
    .clrEv   (slvU1Clr),
    .flag_q  (user1)
  );

  btimr_flag #(
    .RESET_VAL (IRQ_INIT)
  ) u_irq (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setEv   (slvIrqSet),
    .clrEv   (hstIrqClr),
    .flag_q  (irq)
  );

  // host writes a definite value, so set and clear never meet here
  btimr_flag #(
    .RESET_VAL (IRQ_EN_INIT)
  ) u_irq_en (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setEv   (irqEnSet),
    .clrEv   (irqEnClr),
    .flag_q  (irqEn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // plain storage bits

  // reserved bits are writable from both sides; host wins a same-cycle race
  wire logic [1:0] rsvdHst = hstWdata[`BTIMR_BIT_RSVD_HI:`BTIMR_BIT_RSVD_LO];
  wire logic [1:0] rsvdSlv = slvWdata[`BTIMR_BIT_RSVD_HI:`BTIMR_BIT_RSVD_LO];
  wire logic [1:0] rsvd_d  = hstWr ? rsvdHst : (slvWr ? rsvdSlv : rsvd_q);

  // user_flag_3 is the slave's alone; the host neither sees nor writes it
  wire logic user3_d = slvWr ? slvWdata[`BTIMR_BIT_USER3] : user3_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rsvd_q  <= RSVD_INIT;
      user3_q <= USER3_INIT;
    end
    else
    begin
      rsvd_q  <= rsvd_d;
      user3_q <= user3_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read views

  // the reset request stays hidden from the host unless readback is enabled
  wire logic hstRstView = rstReq & resetReadbackEnable;

  // bit 4 belongs to the slave alone and reads 0 here
  wire btimr_byte_type hstView = {
    hstRstView,
    rsvd_q,
    1'b0,
    user2,
    user1,
    irq,
    irqEn
  };
  wire btimr_byte_type slvView = regImage;

  wire btimr_byte_type slvRdata_d = slvRd ? slvView : slvRdata_q;
  wire btimr_byte_type hstRdata_d = hstRd ? hstView : hstRdata_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slvRdata_q   <= 8'h00;
      hstRdata_q   <= 8'h00;
      slvRdValid_q <= 1'b0;
      hstRdValid_q <= 1'b0;
    end
    else
    begin
      slvRdata_q   <= slvRdata_d;
      hstRdata_q   <= hstRdata_d;
      slvRdValid_q <= slvRd;
      hstRdValid_q <= hstRd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered copies for the rest of the device

  // next values, so the mirrors line up with the flag cells cycle for cycle
  wire logic rstReq_d = flagNext(hstRstSet, slvRstClr, rstReq);
  wire logic user2_d  = flagNext(u2Set, slvU2Clr, user2);
  wire logic user1_d  = flagNext(u1Set, slvU1Clr, user1);
  wire logic irq_d    = flagNext(slvIrqSet, hstIrqClr, irq);
  wire logic irqEn_d  = flagNext(irqEnSet, irqEnClr, irqEn);

  // pending is a level for host logic only; no serial interrupt is sent
  wire logic pending_d = irq_d & irqEn_d;

  // one-cycle pulse when a reset request newly appears
  wire logic rstRise_d = rstReq_d & ~rstReq;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slaveResetReq_q        <= RST_REQ_INIT;
      userFlag3_q            <= USER3_INIT;
      userFlag2_q            <= USER2_INIT;
      userFlag1_q            <= USER1_INIT;
      slaveToHostIrq_q       <= IRQ_INIT;
      slaveToHostIrqEnable_q <= IRQ_EN_INIT;
      hostIrqPending_q       <= IRQ_INIT & IRQ_EN_INIT;
      slaveResetRise_q       <= 1'b0;
    end
    else
    begin
      slaveResetReq_q        <= rstReq_d;
      userFlag3_q            <= user3_d;
      userFlag2_q            <= user2_d;
      userFlag1_q            <= user1_d;
      slaveToHostIrq_q       <= irq_d;
      slaveToHostIrqEnable_q <= irqEn_d;
      hostIrqPending_q       <= pending_d;
      slaveResetRise_q       <= rstRise_d;
    end
  end

endmodule : btimr_core
`default_nettype wire

// *** logic/btimr_cfg.svh ***
// constants for the block-transfer host interrupt mask register
// Overview of operation
// - host writing 1 to slave_reset_req sets it; reset then in progress.
// - host writing 0 to slave_reset_req leaves the stored value unchanged.
// - host reads slave_reset_req as 0 unless reset_readback_enable is set.
// - slave_reset_req clears only on a slave 0 write after reading 1.
// - host writing 0 sets user_flag_2 or user_flag_1; writing 1 does nothing.
// - user flag clears on a slave 0 write after reading it as 1.
// - user flag also sets on a slave 1 write after reading it as 0.
// - slave_to_host_irq tells the host that an attention flag was raised.
// - slave_to_host_irq sets only on slave 1 write after reading 0.
// - host writing 1 clears slave_to_host_irq; writing 0 has no effect.
// - raising slave_to_host_irq emits no serial interrupt; firmware does that.
// - host writes slave_to_host_irq_enable freely; slave only reads it.
`ifndef BTIMR_CFG_SVH
`define BTIMR_CFG_SVH

`define BTIMR_DATA_W        8
`define BTIMR_BIT_RST_REQ   7
`define BTIMR_BIT_RSVD_HI   6
`define BTIMR_BIT_RSVD_LO   5
`define BTIMR_BIT_USER3     4
`define BTIMR_BIT_USER2     3
`define BTIMR_BIT_USER1     2
`define BTIMR_BIT_IRQ       1
`define BTIMR_BIT_IRQ_EN    0
`define BTIMR_RESET_VALUE   8'h00
`define BTIMR_READ_LATENCY  1

`endif

// *** logic/btimr_pkg.sv ***
// types shared by the host interrupt mask register design
`default_nettype none
package btimr_pkg;
  typedef logic [7:0] btimr_byte_type;
  typedef enum logic {BTIMR_SIDE_SLAVE, BTIMR_SIDE_HOST} btimr_side_type;
endpackage : btimr_pkg
`default_nettype wire

// *** logic/btimr_flag.sv ***
// one hardware flag with separate set and clear events
`timescale 1ns/1ps
`default_nettype none
module btimr_flag
  import btimr_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // events
  input  wire logic setEv,
  input  wire logic clrEv,
  // state
  output logic      flag_q
);
  // set beats clear so a racing set is never lost
  wire logic flag_d = setEv ? 1'b1 : (clrEv ? 1'b0 : flag_q);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flag_q <= RESET_VAL;
    else
      flag_q <= flag_d;
  end
endmodule : btimr_flag
`default_nettype wire

// *** logic/btimr_read_arm.sv ***
// snapshot of the last slave read, consumed by the next slave write
`timescale 1ns/1ps
`default_nettype none
module btimr_read_arm
  import btimr_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // slave accesses
  input  wire logic             rdEn,
  input  wire logic [WIDTH-1:0] rdVal,
  input  wire logic             wrEn,
  // qualifiers for a write in this cycle
  output logic      [WIDTH-1:0] seenOne,
  output logic      [WIDTH-1:0] seenZero
);
  logic [WIDTH-1:0] snap_q;
  logic             valid_q;

  // a write spends the snapshot; a read in the same cycle re-arms it
  wire logic             valid_d = rdEn | (valid_q & ~wrEn);
  wire logic [WIDTH-1:0] snap_d  = rdEn ? rdVal : snap_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      valid_q <= 1'b0;
      snap_q  <= '0;
    end
    else
    begin
      valid_q <= valid_d;
      snap_q  <= snap_d;
    end
  end

  assign seenOne  = {WIDTH{valid_q}} & snap_q;
  assign seenZero = {WIDTH{valid_q}} & ~snap_q;
endmodule : btimr_read_arm
`default_nettype wire

// *** tb/btimr_core_asserts.sv ***
// port checker for the host interrupt mask register
`timescale 1ns/1ps
`default_nettype none
module btimr_core_asserts
  import btimr_pkg::*;
(
  // clock and reset
  input wire logic           clk_sys,
  input wire logic           rst_n,
  // accesses
  input wire logic           slvWr,
  input wire btimr_byte_type slvWdata,
  input wire logic           hstRd,
  input wire logic           hstWr,
  input wire btimr_byte_type hstWdata,
  input wire btimr_byte_type hstRdata_q,
  input wire logic           resetReadbackEnable,
  // state
  input wire logic           slaveResetReq_q,
  input wire logic           userFlag2_q,
  input wire logic           slaveToHostIrq_q,
  input wire logic           slaveToHostIrqEnable_q,
  input wire logic           hostIrqPending_q,
  input wire logic           slaveResetRise_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence hostSetRst;
    hstWr && hstWdata[7] && !slaveResetReq_q;
  endsequence
  sequence risePulse;
    slaveResetReq_q && slaveResetRise_q ##1 !slaveResetRise_q;
  endsequence
  rst_set_a: assert property (hostSetRst |=> risePulse)
    else $error("reset request not raised");
  rst_hold_a: assert property (hstWr && !hstWdata[7] && !slvWr |=> $stable(slaveResetReq_q))
    else $error("host zero changed reset request");
  rst_mask_a: assert property (hstRd && !resetReadbackEnable |=> !hstRdata_q[7])
    else $error("host saw reset request");
  rst_clear_a: assert property ($fell(slaveResetReq_q) |-> $past(slvWr) && !$past(slvWdata[7]))
    else $error("reset request cleared without slave zero");
  user_set_a: assert property (hstWr && !hstWdata[3] |=> userFlag2_q)
    else $error("host zero did not set user flag");
  irq_rise_a: assert property ($rose(slaveToHostIrq_q) |-> $past(slvWr) && $past(slvWdata[1]))
    else $error("irq set without slave one");
  irq_clear_a: assert property (hstWr && hstWdata[1] && !slvWr |=> !slaveToHostIrq_q)
    else $error("host one did not clear irq");
  irq_pend_a: assert property (hostIrqPending_q == (slaveToHostIrq_q && slaveToHostIrqEnable_q))
    else $error("pending differs from irq and enable");
  en_write_a: assert property (hstWr |=> slaveToHostIrqEnable_q == $past(hstWdata[0]))
    else $error("enable not written by host");
  en_hold_a: assert property (!hstWr |=> $stable(slaveToHostIrqEnable_q))
    else $error("enable changed without host write");
  rise_only_a: assert property (slaveResetRise_q |-> slaveResetReq_q && !$past(slaveResetReq_q))
    else $error("reset rise pulse without new request");
endmodule : btimr_core_asserts
bind btimr_core btimr_core_asserts u_btimr_core_asserts (.clk_sys, .rst_n, .slvWr, .slvWdata,
  .hstRd, .hstWr, .hstWdata, .hstRdata_q, .resetReadbackEnable, .slaveResetReq_q,
  .userFlag2_q, .slaveToHostIrq_q, .slaveToHostIrqEnable_q, .hostIrqPending_q,
  .slaveResetRise_q);
`default_nettype wire

// *** tb/btimr_host_model.sv ***
// host side model driving the decoded host strobes
`timescale 1ns/1ps
`default_nettype none
module btimr_host_model
  import btimr_pkg::*;
(
  // clock
  input  wire logic          clk_sys,
  // decoded host access
  output var logic           hstRd,
  output var logic           hstWr,
  output var btimr_byte_type hstWdata
);
  // no serial interrupt input: host learns of irq only by reading
  initial
  begin
    hstRd = 1'h0;
    hstWr = 1'h0;
    hstWdata = 8'h00;
  end
  // released data inverted so a stale value cannot pass
  task automatic wr(input btimr_byte_type d);
    @(posedge clk_sys);
    hstWr <= 1'h1;
    hstWdata <= d;
    @(posedge clk_sys);
    hstWr <= 1'h0;
    hstWdata <= ~d;
  endtask : wr
  task automatic rd();
    @(posedge clk_sys);
    hstRd <= 1'h1;
    @(posedge clk_sys);
    hstRd <= 1'h0;
  endtask : rd
endmodule : btimr_host_model
`default_nettype wire

// *** tb/btimr_tb_top.sv ***
// testbench for the host interrupt mask register
`timescale 1ns/1ps
`default_nettype none
module btimr_tb_top
  import btimr_pkg::*;
;
  logic           clk_sys = 1'h0, rst_n = 1'h0, rbEn = 1'h0, armed = 1'h0;
  logic           slvRd = 1'h0, slvWr = 1'h0, hstRd, hstWr, slvRdValid_q, hstRdValid_q;
  logic           req, u3, u2, u1, irq, en, pend;
  btimr_byte_type slvWdata = 8'h00, hstWdata, slvRdata_q, hstRdata_q, d;
  btimr_byte_type m = 8'h00, snap = 8'h00, expQ[$];
  int             bad_count = 0, check_count = 0, k;
  initial forever #2 clk_sys = ~clk_sys;
  btimr_core u_btimr_core (.clk_sys, .rst_n, .slvRd, .slvWr, .slvWdata, .slvRdata_q,
    .slvRdValid_q, .hstRd, .hstWr, .hstWdata, .hstRdata_q, .hstRdValid_q,
    .resetReadbackEnable(rbEn), .slaveResetReq_q(req), .userFlag3_q(u3), .userFlag2_q(u2),
    .userFlag1_q(u1), .slaveToHostIrq_q(irq), .slaveToHostIrqEnable_q(en),
    .hostIrqPending_q(pend), .slaveResetRise_q());
  btimr_host_model u_btimr_host_model (.clk_sys, .hstRd, .hstWr, .hstWdata);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input btimr_byte_type got, input btimr_byte_type exp);
    check_count++;
    if (got !== exp)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // the read snapshot decides conditional slave writes
  function automatic btimr_byte_type sNext(input btimr_byte_type v);
    btimr_byte_type r;
    r = m;
    r[6:4] = v[6:4];
    if (armed)
      begin
        if (snap[7] && !v[7]) r[7] = 1'h0;
        for (int i = 2; i < 4; i++) if (snap[i] != v[i]) r[i] = v[i];
        if (!snap[1] && v[1]) r[1] = 1'h1;
      end
    return r;
  endfunction : sNext
  task automatic slvOp(input logic wr, input btimr_byte_type v);
    @(posedge clk_sys);
    slvRd <= !wr;
    slvWr <= wr;
    slvWdata <= v;
    @(posedge clk_sys);
    slvRd <= 1'h0;
    slvWr <= 1'h0;
    slvWdata <= ~v;
    if (wr) m = sNext(v);
    else expQ.push_back(m);
    armed = !wr;
    snap = m;
  endtask : slvOp
  task automatic hstOp(input logic wr, input btimr_byte_type v);
    if (wr)
      begin
        u_btimr_host_model.wr(v);
        m[7] = m[7] | v[7];
        m[6:5] = v[6:5];
        m[3:2] = m[3:2] | ~v[3:2];
        m[1] = m[1] & ~v[1];
        m[0] = v[0];
      end
    else
      begin
        u_btimr_host_model.rd();
        expQ.push_back({m[7] & rbEn, m[6:5], 1'h0, m[3:0]});
      end
  endtask : hstOp
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    if (slvRdValid_q === 1'h1) chk(slvRdata_q, expQ.pop_front());
    if (hstRdValid_q === 1'h1) chk(hstRdata_q, expQ.pop_front());
  end
  initial
  begin
    #80000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    k = $urandom(37405);
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    slvOp(1'h0, 8'h00);
    hstOp(1'h0, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 400; i++)
    begin
      k = $urandom % 4;
      d = 8'($urandom);
      case (k)
        0: slvOp(1'h0, d);
        1: slvOp(1'h1, d);
        2: hstOp(1'h0, d);
        default: hstOp(1'h1, d);
      endcase
      @(posedge clk_sys);
      chk({req, u3, u2, u1, irq, en, pend, 1'h0}, {m[7], m[4:0], m[1] & m[0], 1'h0});
      rbEn <= 1'($urandom);
    end
    $display("test random done");
    repeat (4) @(posedge clk_sys);
    chk(8'(expQ.size()), 8'h00);
    end_of_test();
  end
endmodule : btimr_tb_top
`default_nettype wire
